// ==== shared/app_pkg.sv ====
package app_pkg;
  // Buffer memory word offsets of one axis, then the axis 2 base and axis 2 config addresses
  localparam int BM_AW = 11;
  localparam int BM_DW = 16;
  localparam logic [10:0] BM_SENS_LO = 11'h000;
  localparam logic [10:0] BM_SENS_HI = 11'h001;
  localparam logic [10:0] BM_CW_LO = 11'h002;
  localparam logic [10:0] BM_CW_HI = 11'h003;
  localparam logic [10:0] BM_CCW_LO = 11'h004;
  localparam logic [10:0] BM_CCW_HI = 11'h005;
  localparam logic [10:0] BM_STATUS = 11'h006;
  localparam logic [10:0] BM_ERR = 11'h007;
  localparam logic [10:0] BM_PRESET_LO = 11'h2B2;
  localparam logic [10:0] BM_PRESET_HI = 11'h2B3;
  localparam logic [10:0] BM_INHIBIT = 11'h2B6;
  localparam logic [10:0] BM_AXIS_CFG = 11'h2BE;
  localparam logic [10:0] BM_AXIS2_BASE = 11'h3E8;
  localparam logic [10:0] BM_AXIS2_CFG = 11'h6A6;
  localparam int BM_STATUS_FAULT_BIT = 0;
  localparam int AXIS_CFG_EN_BIT = 0;
  // Error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_WR_PROT_BASE = 16'h000A;
  localparam logic [15:0] ERR_SENSOR = 16'h0016;
  localparam logic [15:0] ERR_DATA = 16'h0045;
  localparam logic [15:0] ERR_PRESET_RANGE = 16'h0075;
  // Discrete points, 32 each way
  localparam int IO_POINTS = 32;
  localparam int PT_ONLINE = 1;
  localparam int PT_SENSOR_FAULT = 4;
  localparam int PT_ERR_AXIS1 = 5;
  localparam int PT_ERR_AXIS2 = 9;
  localparam int PT_READY_REQ = 16;
  localparam int PT_PRESET_AXIS1 = 19;
  localparam int PT_PRESET_AXIS2 = 22;
  localparam int PT_ERR_CLEAR = 28;
  // Timing
  localparam int CLK_KHZ = 40000;
  localparam int PRESET_SETTLE_MS = 12;
  localparam int PRESET_GAP_MS = 100;
  localparam int CLEAR_HOLD_MS = 12;
  localparam int PRESET_SETTLE_CYC = PRESET_SETTLE_MS * CLK_KHZ;
  localparam int PRESET_GAP_CYC = PRESET_GAP_MS * CLK_KHZ;
  localparam int CLEAR_HOLD_CYC = CLEAR_HOLD_MS * CLK_KHZ;
  localparam int HOST_SCAN_CYC = 4;
  // Host controller registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BM_ADDR = 8'h08;
  localparam logic [7:0] REG_BM_DATA = 8'h0C;
  localparam logic [7:0] REG_BM_READ = 8'h10;
  localparam logic [7:0] REG_PRESET = 8'h14;
  localparam logic [7:0] REG_CLEAR = 8'h18;
  localparam int CTRL_READY_BIT = 0;
  localparam int ST_READY = 0;
  localparam int ST_ONLINE = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_ERR1 = 3;
  localparam int ST_ERR2 = 4;
  localparam int ST_BUSY = 5;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    DS_OFFLINE = 2'b01,
    DS_ONLINE = 2'b10
  } app_dev_state_e;

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_BUS = 5'b00010,
    HS_WAIT = 5'b00100,
    HS_PULSE = 5'b01000,
    HS_CLEAR = 5'b10000
  } app_host_state_e;
endpackage : app_pkg

// ==== shared/app_link_if.sv ====
`timescale 1ns/1ps
interface app_link_if (
  input wire logic clkSys,
  input wire logic rst
);
  logic [31:0] devicePoints;
  logic [31:0] hostPoints;
  logic [10:0] bmAddr;
  logic bmWrite;
  logic bmRead;
  logic [15:0] bmWData;
  logic [15:0] bmRData;
  logic bmAck;

  modport devicePort (
    input clkSys, rst, hostPoints, bmAddr, bmWrite, bmRead, bmWData,
    output devicePoints, bmRData, bmAck
  );
  modport hostPort (
    input clkSys, rst, devicePoints, bmRData, bmAck,
    output hostPoints, bmAddr, bmWrite, bmRead, bmWData
  );
endinterface : app_link_if

// ==== core/app_axis.sv ====
`timescale 1ns/1ps
module app_axis #(
  parameter logic [31:0] PRESET_MAX = 32'h7FFF_FFFF
) (
  input wire logic clkSys,
  input wire logic rst,
  input wire logic run,
  input wire logic [31:0] sensorPos,
  input wire logic sensorFault,
  input wire logic presetCmd,
  input wire logic [31:0] presetValue,
  input wire logic [15:0] presetInhibit,
  input wire logic powerCheck,
  input wire logic retainedValid,
  input wire logic protErr,
  input wire logic [15:0] protCode,
  input wire logic clearErr,
  output logic [31:0] posCw,
  output logic [31:0] posCcw,
  output logic [15:0] errorCode,
  output logic presetDone
);
  logic cmdPrev;
  logic cmdRise;
  logic presetOk;
  logic rangeBad;
  logic applyQ;
  logic [31:0] offsetCw;
  logic [31:0] offsetCcw;

  assign cmdRise = presetCmd && !cmdPrev;
  assign presetOk = cmdRise && run
    && !sensorFault
    && presetInhibit == app_pkg::ERR_NONE;
  assign rangeBad = presetValue > PRESET_MAX;

  always_ff @(posedge clkSys or posedge rst) begin
    if (rst) begin
      cmdPrev <= 1'b0;
    end else begin
      cmdPrev <= presetCmd;
    end
  end

  // Offsets are latched at the preset, so both positions follow the shaft from the preset value
  always_ff @(posedge clkSys or posedge rst) begin
    if (rst) begin
      offsetCw <= '0;
      offsetCcw <= '0;
    end else if (presetOk && !rangeBad) begin
      offsetCw <= presetValue - sensorPos;
      offsetCcw <= presetValue + sensorPos;
    end
  end

  always_ff @(posedge clkSys or posedge rst) begin
    if (rst) begin
      posCw <= '0;
      posCcw <= '0;
    end else if (run) begin
      posCw <= sensorPos + offsetCw;
      posCcw <= offsetCcw - sensorPos;
    end
  end

  // New value is visible two edges after the rise, far inside the limit
  always_ff @(posedge clkSys or posedge rst) begin
    if (rst) begin
      applyQ <= 1'b0;
      presetDone <= 1'b0;
    end else begin
      applyQ <= presetOk && !rangeBad;
      presetDone <= applyQ;
    end
  end

  // Any new error outranks a clear in the same cycle
  always_ff @(posedge clkSys or posedge rst) begin
    if (rst) begin
      errorCode <= app_pkg::ERR_NONE;
    end else if (sensorFault) begin
      errorCode <= app_pkg::ERR_SENSOR;
    end else if (powerCheck && !retainedValid) begin
      errorCode <= app_pkg::ERR_DATA;
    end else if (presetOk && rangeBad) begin
      errorCode <= app_pkg::ERR_PRESET_RANGE;
    end else if (protErr) begin
      errorCode <= protCode;
    end else if (clearErr) begin
      errorCode <= app_pkg::ERR_NONE;
    end
  end
endmodule : app_axis

// ==== core/app_device.sv ====
`timescale 1ns/1ps
module app_device #(
  parameter int CLEAR_SAMPLE_CYCLES = app_pkg::CLEAR_HOLD_CYC,
  parameter logic [31:0] PRESET_MAX = 32'h7FFF_FFFF
) (
  app_link_if.devicePort link,
  input wire logic [63:0] sensorPos,
  input wire logic [1:0] sensorFault,
  input wire logic [1:0] retainedValid,
  output logic [1:0] presetDone
);
  localparam int AXES = 2;

  app_pkg::app_dev_state_e state;
  app_pkg::app_dev_state_e next_state;
  logic readyReq;
  logic online;
  logic checked;
  logic powerCheck;
  logic [31:0] clrCnt;
  logic clrTick;
  logic clearErr;
  logic axisSel;
  logic [10:0] off;
  logic protHit;
  logic [15:0] protCode;
  logic [15:0] readWord;
  logic [1:0] presetCmd;
  logic [31:0] presetValue [AXES];
  logic [15:0] presetInhibit [AXES];
  logic [15:0] axisCfg [AXES];
  logic [31:0] posCw [AXES];
  logic [31:0] posCcw [AXES];
  logic [15:0] errorCode [AXES];

  assign readyReq = link.hostPoints[app_pkg::PT_READY_REQ];
  assign presetCmd = {link.hostPoints[app_pkg::PT_PRESET_AXIS2],
                      link.hostPoints[app_pkg::PT_PRESET_AXIS1]};
  assign online = state == app_pkg::DS_ONLINE;

  always_comb begin
    case (state)
      app_pkg::DS_OFFLINE: begin
        next_state = readyReq ? app_pkg::DS_ONLINE : app_pkg::DS_OFFLINE;
      end
      app_pkg::DS_ONLINE: begin
        next_state = readyReq ? app_pkg::DS_ONLINE : app_pkg::DS_OFFLINE;
      end
      default: begin
        next_state = app_pkg::DS_OFFLINE;
      end
    endcase
  end

  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      state <= app_pkg::DS_OFFLINE;
    end else begin
      state <= next_state;
    end
  end

  // Retained data is judged once, on the first edge after reset release
  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      checked <= 1'b0;
    end else begin
      checked <= 1'b1;
    end
  end
  assign powerCheck = !checked;

  // Clear is only looked at once per sample period, so a short pulse
  // can slip between two looks
  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      clrCnt <= '0;
    end else if (clrCnt >= 32'(CLEAR_SAMPLE_CYCLES - 1)) begin
      clrCnt <= '0;
    end else begin
      clrCnt <= clrCnt + 32'h0000_0001;
    end
  end
  assign clrTick = clrCnt >= 32'(CLEAR_SAMPLE_CYCLES - 1);
  assign clearErr = clrTick
    && link.hostPoints[app_pkg::PT_ERR_CLEAR];

  // Axis 2 words sit a fixed distance above axis 1
  assign axisSel = link.bmAddr >= app_pkg::BM_AXIS2_BASE;
  assign off = axisSel ? link.bmAddr - app_pkg::BM_AXIS2_BASE : link.bmAddr;
  assign protHit = link.bmWrite && online && off <= app_pkg::BM_ERR;
  assign protCode = app_pkg::ERR_WR_PROT_BASE + 16'(off);

  for (genvar a = 0; a < AXES; a++) begin : gAxis
    logic hit;
    logic run;
    assign hit = link.bmWrite && axisSel == 1'(a);
    assign run = online && axisCfg[a][app_pkg::AXIS_CFG_EN_BIT];

    always_ff @(posedge link.clkSys or posedge link.rst) begin
      if (link.rst) begin
        presetValue[a] <= '0;
        presetInhibit[a] <= '0;
        axisCfg[a] <= '0;
      end else if (hit) begin
        if (off == app_pkg::BM_PRESET_LO) begin
          presetValue[a][15:0] <= link.bmWData;
        end
        if (off == app_pkg::BM_PRESET_HI) begin
          presetValue[a][31:16] <= link.bmWData;
        end
        if (off == app_pkg::BM_INHIBIT) begin
          presetInhibit[a] <= link.bmWData;
        end
        if (off == app_pkg::BM_AXIS_CFG) begin
          axisCfg[a] <= link.bmWData;
        end
      end
    end

    app_axis #(
      .PRESET_MAX(PRESET_MAX)
    ) uAxis (
      .clkSys(link.clkSys),
      .rst(link.rst),
      .run(run),
      .sensorPos(sensorPos[32 * a +: 32]),
      .sensorFault(sensorFault[a]),
      .presetCmd(presetCmd[a]),
      .presetValue(presetValue[a]),
      .presetInhibit(presetInhibit[a]),
      .powerCheck(powerCheck),
      .retainedValid(retainedValid[a]),
      .protErr(hit && protHit),
      .protCode(protCode),
      .clearErr(clearErr),
      .posCw(posCw[a]),
      .posCcw(posCcw[a]),
      .errorCode(errorCode[a]),
      .presetDone(presetDone[a])
    );
  end

  always_comb begin
    readWord = '0;
    case (off)
      app_pkg::BM_SENS_LO: readWord = sensorPos[32 * axisSel +: 16];
      app_pkg::BM_SENS_HI: readWord = sensorPos[32 * axisSel + 16 +: 16];
      app_pkg::BM_CW_LO: readWord = posCw[axisSel][15:0];
      app_pkg::BM_CW_HI: readWord = posCw[axisSel][31:16];
      app_pkg::BM_CCW_LO: readWord = posCcw[axisSel][15:0];
      app_pkg::BM_CCW_HI: readWord = posCcw[axisSel][31:16];
      app_pkg::BM_STATUS: begin
        readWord[app_pkg::BM_STATUS_FAULT_BIT] = sensorFault[axisSel];
      end
      app_pkg::BM_ERR: readWord = errorCode[axisSel];
      app_pkg::BM_PRESET_LO: readWord = presetValue[axisSel][15:0];
      app_pkg::BM_PRESET_HI: readWord = presetValue[axisSel][31:16];
      app_pkg::BM_INHIBIT: readWord = presetInhibit[axisSel];
      app_pkg::BM_AXIS_CFG: readWord = axisCfg[axisSel];
      default: readWord = '0;
    endcase
  end

  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      link.bmAck <= 1'b0;
      link.bmRData <= '0;
    end else begin
      link.bmAck <= link.bmWrite || link.bmRead;
      if (link.bmRead) begin
        link.bmRData <= readWord;
      end
    end
  end

  // Unused points of the 32-point block stay low
  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      link.devicePoints <= '0;
    end else begin
      link.devicePoints <= '0;
      link.devicePoints[app_pkg::PT_ONLINE] <= online;
      link.devicePoints[app_pkg::PT_SENSOR_FAULT] <= |sensorFault;
      link.devicePoints[app_pkg::PT_ERR_AXIS1] <=
        errorCode[0] != app_pkg::ERR_NONE;
      link.devicePoints[app_pkg::PT_ERR_AXIS2] <=
        errorCode[1] != app_pkg::ERR_NONE;
    end
  end
endmodule : app_device

// ==== core/app_host.sv ====
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module app_host #(
  parameter int SETTLE_CYCLES = app_pkg::PRESET_SETTLE_CYC,
  parameter int GAP_CYCLES = app_pkg::PRESET_GAP_CYC,
  parameter int CLEAR_CYCLES = app_pkg::CLEAR_HOLD_CYC,
  parameter int SCAN_CYCLES = app_pkg::HOST_SCAN_CYC
) (
  app_link_if.hostPort link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  app_pkg::app_host_state_e state;
  app_pkg::app_host_state_e next_state;
  logic accept;
  logic wrPend;
  logic [7:0] wrAddr;
  logic readyReq;
  logic [1:0] cfgDone;
  logic presetAxis;
  logic [15:0] bmRdData;
  logic [31:0] holdCnt;
  logic [31:0] sinceWrite;
  logic [31:0] lowCnt;
  logic [31:0] status;
  logic idle;
  logic cmdLow;
  logic holdDone;
  logic [1:0] hostPreset;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign accept = hsel && htrans == app_pkg::HTRANS_NONSEQ && hready
    && hsize != 3'h7;
  assign idle = state == app_pkg::HS_IDLE;
  assign hostPreset = {link.hostPoints[app_pkg::PT_PRESET_AXIS2],
                       link.hostPoints[app_pkg::PT_PRESET_AXIS1]};
  assign cmdLow = hostPreset == 2'h0;
  assign holdDone = holdCnt == 32'h0000_0000;

  always_comb begin
    status = '0;
    status[app_pkg::ST_READY] = readyReq;
    status[app_pkg::ST_ONLINE] = link.devicePoints[app_pkg::PT_ONLINE];
    status[app_pkg::ST_FAULT] = link.devicePoints[app_pkg::PT_SENSOR_FAULT];
    status[app_pkg::ST_ERR1] = link.devicePoints[app_pkg::PT_ERR_AXIS1];
    status[app_pkg::ST_ERR2] = link.devicePoints[app_pkg::PT_ERR_AXIS2];
    status[app_pkg::ST_BUSY] = !idle;
  end

  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
      hrdata <= '0;
    end else begin
      wrPend <= accept && hwrite;
      if (accept) begin
        wrAddr <= haddr[7:0];
      end
      if (accept && !hwrite) begin
        case (haddr[7:0])
          app_pkg::REG_CTRL: hrdata <= 32'(readyReq);
          app_pkg::REG_STATUS: hrdata <= status;
          app_pkg::REG_BM_ADDR: hrdata <= 32'(link.bmAddr);
          app_pkg::REG_BM_DATA: hrdata <= 32'(bmRdData);
          default: hrdata <= '0;
        endcase
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      app_pkg::HS_IDLE: begin
        if (wrPend && (wrAddr == app_pkg::REG_BM_DATA
            || wrAddr == app_pkg::REG_BM_READ)) begin
          next_state = app_pkg::HS_BUS;
        end else if (wrPend && wrAddr == app_pkg::REG_PRESET) begin
          next_state = app_pkg::HS_WAIT;
        end else if (wrPend && wrAddr == app_pkg::REG_CLEAR) begin
          next_state = app_pkg::HS_CLEAR;
        end
      end
      app_pkg::HS_BUS: begin
        if (link.bmAck) begin
          next_state = app_pkg::HS_IDLE;
        end
      end
      app_pkg::HS_WAIT: begin
        if (sinceWrite >= 32'(SETTLE_CYCLES)
            && lowCnt >= 32'(GAP_CYCLES)) begin
          next_state = app_pkg::HS_PULSE;
        end
      end
      app_pkg::HS_PULSE, app_pkg::HS_CLEAR: begin
        if (holdDone) begin
          next_state = app_pkg::HS_IDLE;
        end
      end
      default: next_state = app_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      state <= app_pkg::HS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      holdCnt <= '0;
    end else if (state == app_pkg::HS_WAIT) begin
      holdCnt <= 32'(SCAN_CYCLES - 1);
    end else if (idle) begin
      holdCnt <= 32'(CLEAR_CYCLES - 1);
    end else if (!holdDone) begin
      holdCnt <= holdCnt - 32'h0000_0001;
    end
  end

  // Both timers start saturated so the first preset is not delayed
  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      sinceWrite <= 32'(SETTLE_CYCLES);
      lowCnt <= 32'(GAP_CYCLES);
    end else begin
      if (link.bmWrite) begin
        sinceWrite <= '0;
      end else if (sinceWrite < 32'(SETTLE_CYCLES)) begin
        sinceWrite <= sinceWrite + 32'h0000_0001;
      end
      if (!cmdLow) begin
        lowCnt <= '0;
      end else if (lowCnt < 32'(GAP_CYCLES)) begin
        lowCnt <= lowCnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      readyReq <= 1'b0;
      cfgDone <= '0;
      presetAxis <= 1'b0;
      bmRdData <= '0;
      link.bmAddr <= '0;
      link.bmWData <= '0;
      link.bmWrite <= 1'b0;
      link.bmRead <= 1'b0;
    end else begin
      link.bmWrite <= idle && wrPend && wrAddr == app_pkg::REG_BM_DATA;
      link.bmRead <= idle && wrPend && wrAddr == app_pkg::REG_BM_READ;
      if (idle && wrPend && wrAddr == app_pkg::REG_BM_DATA) begin
        link.bmWData <= hwdata[15:0];
      end
      if (wrPend && wrAddr == app_pkg::REG_BM_ADDR && idle) begin
        link.bmAddr <= hwdata[10:0];
      end
      if (idle && wrPend && wrAddr == app_pkg::REG_PRESET) begin
        presetAxis <= hwdata[0];
      end
      if (wrPend && wrAddr == app_pkg::REG_CTRL) begin
        readyReq <= hwdata[app_pkg::CTRL_READY_BIT]
          && cfgDone == 2'h3;
      end
      if (link.bmWrite && link.bmAddr == app_pkg::BM_AXIS_CFG) begin
        cfgDone[0] <= 1'b1;
      end
      if (link.bmWrite && link.bmAddr == app_pkg::BM_AXIS2_CFG) begin
        cfgDone[1] <= 1'b1;
      end
      if (state == app_pkg::HS_BUS && link.bmAck && !link.bmWrite) begin
        bmRdData <= link.bmRData;
      end
    end
  end

  always_ff @(posedge link.clkSys or posedge link.rst) begin
    if (link.rst) begin
      link.hostPoints <= '0;
    end else begin
      link.hostPoints <= '0;
      link.hostPoints[app_pkg::PT_READY_REQ] <= readyReq;
      link.hostPoints[app_pkg::PT_PRESET_AXIS1] <=
        next_state == app_pkg::HS_PULSE && !presetAxis;
      link.hostPoints[app_pkg::PT_PRESET_AXIS2] <=
        next_state == app_pkg::HS_PULSE && presetAxis;
      link.hostPoints[app_pkg::PT_ERR_CLEAR] <=
        next_state == app_pkg::HS_CLEAR;
    end
  end
endmodule : app_host

// ==== verification/app_link_sva.sv ====
`timescale 1ns/1ps
module app_link_sva (
  input wire logic clkSys,
  input wire logic rst,
  input wire logic [31:0] devicePoints,
  input wire logic [31:0] hostPoints,
  input wire logic bmWrite,
  input wire logic bmRead,
  input wire logic bmAck
);
  default clocking @(posedge clkSys); endclocking
  default disable iff (rst);
  // Ready passes the device state flop and then the point flop
  property p_online; hostPoints[16] |=> ##1 devicePoints[1]; endproperty
  a_online: assert property (p_online)
    else $error("online flag did not follow ready request");
  property p_offline; !hostPoints[16] |=> ##1 !devicePoints[1]; endproperty
  a_offline: assert property (p_offline)
    else $error("online flag stayed up without ready request");
  property p_ack; (bmWrite || bmRead) |=> bmAck ##1 !bmAck; endproperty
  a_ack: assert property (p_ack)
    else $error("buffer access not answered by a one-cycle ack");
  property p_fault;
    devicePoints[4] |-> ##[0:2] (devicePoints[5] || devicePoints[9]);
  endproperty
  a_fault: assert property (p_fault)
    else $error("sensor fault without an error flag");
  // Only the documented points may ever move
  property p_spare;
    (devicePoints & 32'hFFFFFDCD) == 32'h0 &&
      (hostPoints & 32'hEFB6FFFF) == 32'h0;
  endproperty
  a_spare: assert property (p_spare)
    else $error("an unassigned point is active");
  property p_scan;
    $rose(hostPoints[19]) |-> hostPoints[19][*4] ##1 !hostPoints[19];
  endproperty
  a_scan: assert property (p_scan)
    else $error("preset command not held one scan");
  property p_gap; $fell(hostPoints[19]) |-> !hostPoints[19][*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("preset command repeated too soon");
  property p_clear; $rose(hostPoints[28]) |-> hostPoints[28][*8]; endproperty
  a_clear: assert property (p_clear)
    else $error("error clear released too early");
endmodule : app_link_sva

// ==== verification/absolute_position_preset_ctrl_test.sv ====
`timescale 1ns/1ps
module absolute_position_preset_ctrl_test;
  logic clkSys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  // Axis 2 starts with invalid retained data
  logic [1:0] htrans = 2'h0, sf = 2'h0, rv = 2'h1, done;
  logic [2:0] hsize = 3'h0;
  logic [63:0] sp = 64'h0000_0100_0000_0200;
  logic hwrite = 1'b0, hrdy, hresp;
  int nFail = 0, nTests = 0, cyc = 0;
  app_link_if link (.clkSys(clkSys), .rst(rst));
  app_host #(.SETTLE_CYCLES(20), .GAP_CYCLES(40), .CLEAR_CYCLES(20))
    app_host_i (.link(link), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata));
  app_device #(.CLEAR_SAMPLE_CYCLES(16)) app_device_i (.link(link),
    .sensorPos(sp), .sensorFault(sf),
    .retainedValid(rv), .presetDone(done));
  app_link_sva app_link_sva_i (.clkSys(clkSys), .rst(rst),
    .devicePoints(link.devicePoints), .hostPoints(link.hostPoints),
    .bmWrite(link.bmWrite), .bmRead(link.bmRead), .bmAck(link.bmAck));
  initial forever #12.5 clkSys = ~clkSys;
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : printVerdict
  always @(posedge clkSys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nFail++;
      printVerdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      nFail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clkSys);
    htrans <= 2'h2;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clkSys); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clkSys); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : ahb
  // Busy may rise a few cycles late, so give it time before polling
  task automatic idle;
    repeat (3) @(posedge clkSys);
    do ahb(1'b0, app_pkg::REG_STATUS, 32'h0);
    while (q[app_pkg::ST_BUSY] !== 1'b0);
  endtask : idle
  task automatic bmw(input logic [10:0] a, input logic [15:0] d);
    idle();
    ahb(1'b1, app_pkg::REG_BM_ADDR, {21'h0, a});
    ahb(1'b1, app_pkg::REG_BM_DATA, {16'h0, d});
  endtask : bmw
  task automatic bmr(input logic [10:0] a);
    idle();
    ahb(1'b1, app_pkg::REG_BM_ADDR, {21'h0, a});
    ahb(1'b1, app_pkg::REG_BM_READ, 32'h0);
    idle();
    ahb(1'b0, app_pkg::REG_BM_DATA, 32'h0);
  endtask : bmr
  task automatic rd32(input logic [10:0] a, input logic [31:0] e);
    logic [15:0] lo;
    bmr(a);
    lo = q[15:0];
    bmr(a + 11'h001);
    chk({q[15:0], lo}, e);
  endtask : rd32
  task automatic preset(input logic ax, input logic hit);
    int n;
    n = 0;
    idle();
    ahb(1'b1, app_pkg::REG_PRESET, {31'h0, ax});
    while (done[ax] !== 1'b1 && n < 200) begin
      @(posedge clkSys);
      n++;
    end
    chk({31'h0, done[ax]}, {31'h0, hit});
  endtask : preset
  task automatic status(input logic [31:0] e);
    idle();
    chk({28'h0, q[app_pkg::ST_ERR2], q[app_pkg::ST_ERR1],
      q[app_pkg::ST_FAULT], q[app_pkg::ST_ONLINE]}, e);
  endtask : status
  initial begin
    repeat (2) @(posedge clkSys);
    rst <= 1'b0;
    bmw(app_pkg::BM_AXIS_CFG, 16'h0001);
    bmw(app_pkg::BM_AXIS2_CFG, 16'h0001);
    bmw(app_pkg::BM_PRESET_LO, 16'h5678);
    bmw(app_pkg::BM_PRESET_HI, 16'h1234);
    bmw(app_pkg::BM_INHIBIT, 16'h0000);
    bmr(app_pkg::BM_AXIS2_BASE + app_pkg::BM_ERR);
    chk({16'h0, q[15:0]}, {16'h0, app_pkg::ERR_DATA});
    ahb(1'b1, app_pkg::REG_CTRL, 32'h1);
    status(32'h9);
    $display("test online done");
    preset(1'b0, 1'b1);
    rd32(app_pkg::BM_CW_LO, 32'h1234_5678);
    rd32(app_pkg::BM_CCW_LO, 32'h1234_5678);
    sp[31:0] <= 32'h0000_0210;
    rd32(app_pkg::BM_CW_LO, 32'h1234_5688);
    rd32(app_pkg::BM_CCW_LO, 32'h1234_5668);
    bmw(app_pkg::BM_AXIS2_BASE + app_pkg::BM_PRESET_LO, 16'h00AB);
    preset(1'b1, 1'b1);
    rd32(app_pkg::BM_AXIS2_BASE + app_pkg::BM_CW_LO, 32'hAB);
    $display("test preset done");
    bmw(app_pkg::BM_PRESET_LO, 16'h0042);
    bmw(app_pkg::BM_INHIBIT, 16'h0001);
    preset(1'b0, 1'b0);
    rd32(app_pkg::BM_CW_LO, 32'h1234_5688);
    bmw(app_pkg::BM_INHIBIT, 16'h0000);
    sf <= 2'h1;
    preset(1'b0, 1'b0);
    status(32'hF);
    bmr(app_pkg::BM_ERR);
    chk({16'h0, q[15:0]}, {16'h0, app_pkg::ERR_SENSOR});
    $display("test inhibit and fault done");
    sf <= 2'h0;
    idle();
    ahb(1'b1, app_pkg::REG_CLEAR, 32'h1);
    repeat (40) @(posedge clkSys);
    status(32'h1);
    bmw(app_pkg::BM_ERR, 16'h0005);
    bmr(app_pkg::BM_ERR);
    chk({16'h0, q[15:0]}, 32'h0000_0011);
    ahb(1'b1, app_pkg::REG_CTRL, 32'h0);
    status(32'h4);
    $display("test clear and stop done");
    printVerdict();
  end
endmodule : absolute_position_preset_ctrl_test
